// ==== lsbe_core.sv ====
`timescale 1ns/1ps
module lsbe_core (
  input wire logic ref_clk, // core instruction clock
  input wire logic reset_n, // async reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused protection
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic [2:0] arprot, // unused protection
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [7:0] workValue, // working register
  output logic [14:0] pcValue, // program counter
  output logic [2:0] flagsValue, // zero, digit carry, carry
  output logic busy // instruction in flight
);
  import lsbe_pkg::*;

  logic [7:0] workReg;
  logic carryFlag;
  logic digitFlag;
  logic zeroFlag;
  logic [14:0] pcReg;
  logic [6:0] fileAddr;
  logic [7:0] fileMem [0:127];
  logic [24:0] cmdReg;
  logic [1:0] lastCycles;
  lsbe_state_type state;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic writeGo;
  logic [31:0] wMask;
  logic [31:0] merged;

  // command decode
  lsbe_op_type opSel;
  logic destFile;
  logic [2:0] bitSel;
  logic [6:0] fileSel;
  logic [8:0] litK;
  logic [7:0] fileVal;
  logic [7:0] bitMask;
  logic [14:0] pcInc;
  logic [8:0] sumVal;
  logic [4:0] nibbleSum;
  logic digitCarry;
  assign opSel = lsbe_op_type'(cmdReg[LSBE_CMD_OP_LSB +: 4]);
  assign destFile = cmdReg[LSBE_CMD_DEST];
  assign bitSel = cmdReg[LSBE_CMD_BIT_LSB +: 3];
  assign fileSel = cmdReg[LSBE_CMD_FILE_LSB +: 7];
  assign litK = cmdReg[LSBE_CMD_LIT_LSB +: 9];
  assign fileVal = fileMem[fileSel];
  assign bitMask = 8'h01 << bitSel;
  assign pcInc = pcReg + 15'h0001;
  assign sumVal = {1'b0, workReg} + {1'b0, fileVal} + {8'h00, carryFlag};
  assign nibbleSum = {1'b0, workReg[3:0]} + {1'b0, fileVal[3:0]} + {4'h0, carryFlag};
  assign digitCarry = nibbleSum[4];

  // execution results
  logic [7:0] result;
  logic next_carry;
  logic next_digit;
  logic next_zero;
  logic writeW;
  logic writeF;
  logic [14:0] next_pc;
  logic twoCycle;
  always_comb begin
    result = fileVal;
    next_carry = carryFlag;
    next_digit = digitFlag;
    next_zero = zeroFlag;
    writeW = 1'b0;
    writeF = 1'b0;
    next_pc = pcInc;
    twoCycle = 1'b0;
    case (opSel)
      LSBE_OP_AND: begin
        result = workReg & fileVal;
        next_zero = (result == 8'h00);
        writeW = !destFile;
        writeF = destFile;
      end
      LSBE_OP_ADDC: begin
        result = sumVal[7:0];
        next_carry = sumVal[8];
        next_digit = digitCarry;
        next_zero = (result == 8'h00);
        writeW = !destFile;
        writeF = destFile;
      end
      LSBE_OP_ASR: begin
        result = {fileVal[7], fileVal[7:1]};
        next_carry = fileVal[0];
        next_zero = (result == 8'h00);
        writeW = !destFile;
        writeF = destFile;
      end
      LSBE_OP_BCLR: begin
        result = fileVal & ~bitMask;
        writeF = 1'b1;
      end
      LSBE_OP_BSET: begin
        result = fileVal | bitMask;
        writeF = 1'b1;
      end
      LSBE_OP_BRA: begin
        next_pc = pcInc + {{6{litK[8]}}, litK};
        twoCycle = 1'b1;
      end
      LSBE_OP_BRW: begin
        next_pc = pcInc + {7'h00, workReg};
        twoCycle = 1'b1;
      end
      LSBE_OP_BTSC: begin
        if (!fileVal[bitSel]) begin
          next_pc = pcReg + 15'h0002;
          twoCycle = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // register read mux, shared by reads and byte-merged writes
  function automatic logic [31:0] regValue(input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h00000000;
    case (addr[7:2])
      LSBE_OFF_CMD[7:2]: v = {7'h00, cmdReg};
      LSBE_OFF_WORK[7:2]: v = {24'h000000, workReg};
      LSBE_OFF_STATUS[7:2]: v = {28'h0000000, busy, zeroFlag, digitFlag, carryFlag};
      LSBE_OFF_PC[7:2]: v = {17'h00000, pcReg};
      LSBE_OFF_FADDR[7:2]: v = {25'h0000000, fileAddr};
      LSBE_OFF_FDATA[7:2]: v = {24'h000000, fileMem[fileAddr]};
      LSBE_OFF_LAST[7:2]: v = {30'h00000000, lastCycles};
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return addr[7:2] <= LSBE_OFF_LAST[7:2];
  endfunction

  // write channels latch independently, commit only while idle
  // so software never races an instruction in flight
  assign awready = !awHeld;
  assign wready = !wHeld;
  assign busy = (state != LSBE_ST_IDLE);
  assign writeGo = awHeld && wHeld && !bvalid && (state == LSBE_ST_IDLE);
  assign wMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
  assign merged = (regValue(awAddrReg) & ~wMask) | (wDataReg & wMask);

  // write address and data holding
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h00000000;
      wStrbReg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrReg <= awaddr;
      end else if (writeGo) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end else if (writeGo) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp <= LSBE_RESP_OKAY;
    end else if (writeGo) begin
      bvalid <= 1'b1;
      bresp <= mapped(awAddrReg) ? LSBE_RESP_OKAY : LSBE_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel, one cycle answer
  assign arready = !rvalid;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= LSBE_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= regValue(araddr);
      rresp <= mapped(araddr) ? LSBE_RESP_OKAY : LSBE_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // sequencer: a command write starts execution
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= LSBE_ST_IDLE;
      cmdReg <= LSBE_CMD_RST;
      lastCycles <= LSBE_CYC_ONE;
    end else begin
      case (state)
        LSBE_ST_IDLE: begin
          if (writeGo && awAddrReg[7:2] == LSBE_OFF_CMD[7:2]) begin
            cmdReg <= merged[24:0];
            state <= LSBE_ST_EXEC;
          end
        end
        LSBE_ST_EXEC: begin
          state <= twoCycle ? LSBE_ST_NOPC : LSBE_ST_IDLE;
          lastCycles <= twoCycle ? LSBE_CYC_TWO : LSBE_CYC_ONE;
        end
        LSBE_ST_NOPC: state <= LSBE_ST_IDLE;
        default: state <= LSBE_ST_IDLE;
      endcase
    end
  end

  // working register and flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      workReg <= LSBE_WORK_RST;
      carryFlag <= 1'b0;
      digitFlag <= 1'b0;
      zeroFlag <= 1'b0;
    end else if (state == LSBE_ST_EXEC) begin
      if (writeW) begin
        workReg <= result;
      end
      carryFlag <= next_carry;
      digitFlag <= next_digit;
      zeroFlag <= next_zero;
    end else if (writeGo && awAddrReg[7:2] == LSBE_OFF_WORK[7:2]) begin
      workReg <= merged[7:0];
    end else if (writeGo && awAddrReg[7:2] == LSBE_OFF_STATUS[7:2]) begin
      carryFlag <= merged[LSBE_ST_C];
      digitFlag <= merged[LSBE_ST_DC];
      zeroFlag <= merged[LSBE_ST_Z];
    end
  end

  // program counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pcReg <= LSBE_PC_RST;
    end else if (state == LSBE_ST_EXEC) begin
      pcReg <= next_pc;
    end else if (writeGo && awAddrReg[7:2] == LSBE_OFF_PC[7:2]) begin
      pcReg <= merged[14:0];
    end
  end

  // file window pointer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fileAddr <= LSBE_FADDR_RST;
    end else if (writeGo && awAddrReg[7:2] == LSBE_OFF_FADDR[7:2]) begin
      fileAddr <= merged[6:0];
    end
  end

  // file memory has no reset; software must load it before use
  always_ff @(posedge ref_clk) begin
    if (state == LSBE_ST_EXEC && writeF) begin
      fileMem[fileSel] <= result;
    end else if (writeGo && awAddrReg[7:2] == LSBE_OFF_FDATA[7:2]) begin
      fileMem[fileAddr] <= merged[7:0];
    end
  end

  assign workValue = workReg;
  assign pcValue = pcReg;
  assign flagsValue = {zeroFlag, digitFlag, carryFlag};

  // checks
  logic isExec;
  logic [14:0] braTarget;
  logic [14:0] brwTarget;
  assign isExec = (state == LSBE_ST_EXEC);
  assign braTarget = pcReg + 15'h0001 + {{6{litK[8]}}, litK};
  assign brwTarget = pcReg + 15'h0001 + {7'h00, workReg};

  sequence s_second;
    (state == LSBE_ST_NOPC) ##1 (state == LSBE_ST_IDLE);
  endsequence

  property p_and;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_AND && !destFile |=> workReg == ($past(workReg) & $past(fileVal))
      && zeroFlag == (workReg == 8'h00) && carryFlag == $past(carryFlag);
  endproperty
  a_and: assert property (p_and) else $error("and result or flags wrong");
  property p_dest;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && destFile && (opSel == LSBE_OP_AND || opSel == LSBE_OP_ADDC) |=> $stable(workReg);
  endproperty
  a_dest: assert property (p_dest) else $error("file destination touched work");
  property p_addc;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_ADDC && !destFile |=> {carryFlag, workReg} == $past(sumVal)
      && digitFlag == $past(digitCarry);
  endproperty
  a_addc: assert property (p_addc) else $error("add with carry wrong");
  property p_asr;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_ASR && !destFile |=> workReg == (($past(fileVal) >> 1)
      | ($past(fileVal) & 8'h80)) && carryFlag == $past(fileVal[0]);
  endproperty
  a_asr: assert property (p_asr) else $error("shift result wrong");
  property p_bclr;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BCLR |-> (result & bitMask) == 8'h00 && writeF
      ##1 $stable(flagsValue);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong");
  property p_bset;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BSET |-> (result & bitMask) == bitMask && writeF
      ##1 $stable(flagsValue);
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");
  property p_bra;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BRA |=> pcReg == $past(braTarget) && $stable(flagsValue);
  endproperty
  a_bra: assert property (p_bra) else $error("branch target wrong");
  property p_bra_two;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BRA |=> s_second;
  endproperty
  a_bra_two: assert property (p_bra_two) else $error("branch not two cycles");
  property p_brw;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BRW |=> pcReg == $past(brwTarget) && $stable(flagsValue)
      ##0 s_second;
  endproperty
  a_brw: assert property (p_brw) else $error("work branch wrong");
  property p_skip;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BTSC && !fileVal[bitSel] |=> pcReg == $past(pcReg) + 15'h0002
      ##0 s_second;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not taken");
  property p_noskip;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && opSel == LSBE_OP_BTSC && fileVal[bitSel] |=> state == LSBE_ST_IDLE
      && pcReg == $past(pcReg) + 15'h0001;
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip taken wrongly");
  property p_nop;
    @(posedge ref_clk) disable iff (!reset_n)
    state == LSBE_ST_NOPC |=> $stable(workReg) && $stable(pcReg) && $stable(flagsValue);
  endproperty
  a_nop: assert property (p_nop) else $error("second cycle not idle");
  property p_zero;
    @(posedge ref_clk) disable iff (!reset_n)
    isExec && writeW && opSel != LSBE_OP_NOP |=> zeroFlag == (workReg == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch");
endmodule

// ==== lsbe_pkg.sv ====
// Operation
// - and work with file, zero only
// - dest bit picks work or file
// - add work, file, carry; set C DC Z
// - shift right keeping msb, lsb to carry
// - clear chosen file bit, flags untouched
// - set chosen file bit, flags untouched
// - branch to pc plus one plus offset
// - literal branch always two cycles
// - branch by unsigned work, two cycles
// - skip next when tested bit clear
// - pc change or skip adds nop cycle
package lsbe_pkg;
  // register byte offsets
  localparam logic [7:0] LSBE_OFF_CMD = 8'h00;
  localparam logic [7:0] LSBE_OFF_WORK = 8'h04;
  localparam logic [7:0] LSBE_OFF_STATUS = 8'h08;
  localparam logic [7:0] LSBE_OFF_PC = 8'h0c;
  localparam logic [7:0] LSBE_OFF_FADDR = 8'h10;
  localparam logic [7:0] LSBE_OFF_FDATA = 8'h14;
  localparam logic [7:0] LSBE_OFF_LAST = 8'h18;
  // command word fields
  localparam int LSBE_CMD_OP_LSB = 0;
  localparam int LSBE_CMD_DEST = 4;
  localparam int LSBE_CMD_BIT_LSB = 5;
  localparam int LSBE_CMD_FILE_LSB = 8;
  localparam int LSBE_CMD_LIT_LSB = 16;
  // status fields
  localparam int LSBE_ST_C = 0;
  localparam int LSBE_ST_DC = 1;
  localparam int LSBE_ST_Z = 2;
  localparam int LSBE_ST_BUSY = 3;
  // reset values
  localparam logic [7:0] LSBE_WORK_RST = 8'h00;
  localparam logic [14:0] LSBE_PC_RST = 15'h0000;
  localparam logic [24:0] LSBE_CMD_RST = 25'h000000f;
  localparam logic [6:0] LSBE_FADDR_RST = 7'h00;
  // instruction cycle counts
  localparam logic [1:0] LSBE_CYC_ONE = 2'h1;
  localparam logic [1:0] LSBE_CYC_TWO = 2'h2;
  // bus answers
  localparam logic [1:0] LSBE_RESP_OKAY = 2'h0;
  localparam logic [1:0] LSBE_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    LSBE_OP_AND = 4'h0,
    LSBE_OP_ADDC = 4'h1,
    LSBE_OP_ASR = 4'h2,
    LSBE_OP_BCLR = 4'h3,
    LSBE_OP_BSET = 4'h4,
    LSBE_OP_BRA = 4'h5,
    LSBE_OP_BRW = 4'h6,
    LSBE_OP_BTSC = 4'h7,
    LSBE_OP_NOP = 4'hf
  } lsbe_op_type;

  typedef enum logic [2:0] {
    LSBE_ST_IDLE = 3'b001,
    LSBE_ST_EXEC = 3'b010,
    LSBE_ST_NOPC = 3'b100
  } lsbe_state_type;
endpackage

// ==== lsbe_core_tb.sv ====
`timescale 1ns/1ps
module lsbe_core_tb;
  import lsbe_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] workValue;
  logic [14:0] pcValue;
  logic [2:0] flagsValue;
  int badCount = 0;
  int comparisons = 0;
  int b;

  lsbe_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .workValue(workValue), .pcValue(pcValue),
    .flagsValue(flagsValue), .busy(busy));

  // free running core clock
  always #5 ref_clk = ~ref_clk;

  task end_sim;
    if (badCount == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task hang(input string what);
    badCount++;
    $display("mismatch %0t timeout in %s", $time, what);
    end_sim();
  endtask

  task cmp_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  // readies are sampled at the falling edge; inputs only move at rising edges
  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone, wDone, bDone, sAw, sW, sB;
    @(posedge ref_clk);
    awDone = 1'b0;
    wDone = 1'b0;
    bDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !bDone; n++) begin
      @(negedge ref_clk);
      sAw = !awDone && awready;
      sW = !wDone && wready;
      sB = (awDone && wDone) ? bvalid : 1'b0;
      r = bresp;
      @(posedge ref_clk);
      if (sAw) begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (sW) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
      if (sB) begin
        bready <= 1'b0;
        bDone = 1'b1;
      end
    end
    if (!bDone) hang("write");
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arDone, rDone;
    @(posedge ref_clk);
    arDone = 1'b0;
    rDone = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !rDone; n++) begin
      @(negedge ref_clk);
      if (arDone && rvalid === 1'b1) begin
        rDone = 1'b1;
        d = rdata;
        r = rresp;
      end
      if (!arDone && arready === 1'b1) begin
        arDone = 1'b1;
        @(posedge ref_clk);
        arvalid <= 1'b0;
      end else begin
        @(posedge ref_clk);
      end
    end
    rready <= 1'b0;
    if (!rDone) hang("read");
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    cmp_resp(r, LSBE_RESP_OKAY);
  endtask

  task chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    cmp_resp(r, LSBE_RESP_OKAY);
    cmp_data(d, e);
  endtask

  // file location goes through the window pointer
  task setf(input logic [6:0] f, input logic [7:0] v);
    wr(LSBE_OFF_FADDR, {25'h0000000, f});
    wr(LSBE_OFF_FDATA, {24'h000000, v});
  endtask

  task chkf(input logic [6:0] f, input logic [7:0] v);
    wr(LSBE_OFF_FADDR, {25'h0000000, f});
    chk(LSBE_OFF_FDATA, {24'h000000, v});
  endtask

  function automatic logic [31:0] mk(lsbe_op_type op, logic d, logic [2:0] bt,
      logic [6:0] f, logic [8:0] k);
    mk = {7'h00, k, 1'b0, f, bt, d, op};
  endfunction

  // run one instruction and check how many cycles it took
  task exec(input logic [31:0] c, input logic [1:0] cyc);
    int n;
    wr(LSBE_OFF_CMD, c);
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk);
      if (busy === 1'b0) break;
    end
    if (n == 20) hang("exec");
    chk(LSBE_OFF_LAST, {30'h00000000, cyc});
  endtask

  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk(LSBE_OFF_WORK, 32'h00000000);
    chk(LSBE_OFF_PC, 32'h00000000);
    chk(LSBE_OFF_STATUS, 32'h00000000);
    chk(LSBE_OFF_CMD, 32'h0000000f);
    axi_read(8'h1c, d, r);
    cmp_resp(r, LSBE_RESP_SLVERR);
    cmp_data(d, 32'h00000000);
    axi_write(8'h20, 32'h000000ff, r);
    cmp_resp(r, LSBE_RESP_SLVERR);
    // byte enables merge with the current value
    wstrb <= 4'h1;
    wr(LSBE_OFF_WORK, 32'h00001234);
    wstrb <= 4'hf;
    chk(LSBE_OFF_WORK, 32'h00000034);
    wstrb <= 4'he;
    wr(LSBE_OFF_WORK, 32'h00000055);
    wstrb <= 4'hf;
    chk(LSBE_OFF_WORK, 32'h00000034);
  endtask

  task t_and;
    wr(LSBE_OFF_STATUS, 32'h3);
    wr(LSBE_OFF_WORK, 32'hf0);
    setf(7'h7f, 8'h0f);
    exec(mk(LSBE_OP_AND, 1'b0, 3'h0, 7'h7f, 9'h000), LSBE_CYC_ONE);
    cmp_data({24'h000000, workValue}, 32'h0);
    cmp_data({29'h00000000, flagsValue}, 32'h7);
    chk(LSBE_OFF_STATUS, 32'h7);
    chkf(7'h7f, 8'h0f);
    wr(LSBE_OFF_WORK, 32'hff);
    setf(7'h05, 8'h3c);
    exec(mk(LSBE_OP_AND, 1'b1, 3'h0, 7'h05, 9'h000), LSBE_CYC_ONE);
    chkf(7'h05, 8'h3c);
    chk(LSBE_OFF_WORK, 32'hff);
    chk(LSBE_OFF_STATUS, 32'h3);
    cmp_data({29'h00000000, flagsValue}, 32'h3);
  endtask

  task t_addc;
    wr(LSBE_OFF_STATUS, 32'h1);
    wr(LSBE_OFF_WORK, 32'h0f);
    setf(7'h09, 8'hf0);
    exec(mk(LSBE_OP_ADDC, 1'b0, 3'h0, 7'h09, 9'h000), LSBE_CYC_ONE);
    chk(LSBE_OFF_WORK, 32'h0);
    chk(LSBE_OFF_STATUS, 32'h7);
    wr(LSBE_OFF_STATUS, 32'h0);
    wr(LSBE_OFF_WORK, 32'h08);
    setf(7'h09, 8'h08);
    exec(mk(LSBE_OP_ADDC, 1'b1, 3'h0, 7'h09, 9'h000), LSBE_CYC_ONE);
    chkf(7'h09, 8'h10);
    chk(LSBE_OFF_WORK, 32'h08);
    chk(LSBE_OFF_STATUS, 32'h2);
  endtask

  task t_asr;
    wr(LSBE_OFF_STATUS, 32'h2);
    setf(7'h14, 8'h81);
    exec(mk(LSBE_OP_ASR, 1'b0, 3'h0, 7'h14, 9'h000), LSBE_CYC_ONE);
    chk(LSBE_OFF_WORK, 32'hc0);
    chk(LSBE_OFF_STATUS, 32'h3);
    wr(LSBE_OFF_STATUS, 32'h0);
    setf(7'h14, 8'h01);
    exec(mk(LSBE_OP_ASR, 1'b1, 3'h0, 7'h14, 9'h000), LSBE_CYC_ONE);
    chkf(7'h14, 8'h00);
    cmp_data({29'h00000000, flagsValue}, 32'h5);
    chk(LSBE_OFF_STATUS, 32'h5);
  endtask

  // every bit position, flags must survive all of them
  task t_bits;
    wr(LSBE_OFF_STATUS, 32'h5);
    for (b = 0; b < 8; b++) begin
      setf(7'h21, 8'h00);
      exec(mk(LSBE_OP_BSET, 1'b0, b[2:0], 7'h21, 9'h000), LSBE_CYC_ONE);
      chkf(7'h21, 8'h01 << b);
      setf(7'h21, 8'hff);
      exec(mk(LSBE_OP_BCLR, 1'b0, b[2:0], 7'h21, 9'h000), LSBE_CYC_ONE);
      chkf(7'h21, ~(8'h01 << b));
    end
    chk(LSBE_OFF_STATUS, 32'h5);
  endtask

  task t_branch;
    wr(LSBE_OFF_STATUS, 32'h7);
    wr(LSBE_OFF_PC, 32'h1000);
    exec(mk(LSBE_OP_BRA, 1'b0, 3'h0, 7'h00, 9'h0ff), LSBE_CYC_TWO);
    chk(LSBE_OFF_PC, 32'h1100);
    exec(mk(LSBE_OP_BRA, 1'b0, 3'h0, 7'h00, 9'h100), LSBE_CYC_TWO);
    chk(LSBE_OFF_PC, 32'h1001);
    exec(mk(LSBE_OP_BRA, 1'b0, 3'h0, 7'h00, 9'h1ff), LSBE_CYC_TWO);
    cmp_data({17'h00000, pcValue}, 32'h1001);
    wr(LSBE_OFF_WORK, 32'hff);
    exec(mk(LSBE_OP_BRW, 1'b0, 3'h0, 7'h00, 9'h000), LSBE_CYC_TWO);
    chk(LSBE_OFF_PC, 32'h1101);
    // counter wraps at fifteen bits
    wr(LSBE_OFF_PC, 32'h7fff);
    exec(mk(LSBE_OP_BRA, 1'b0, 3'h0, 7'h00, 9'h000), LSBE_CYC_TWO);
    chk(LSBE_OFF_PC, 32'h0000);
    chk(LSBE_OFF_STATUS, 32'h7);
  endtask

  task t_skip;
    wr(LSBE_OFF_PC, 32'h0200);
    setf(7'h28, 8'h10);
    exec(mk(LSBE_OP_BTSC, 1'b0, 3'h4, 7'h28, 9'h000), LSBE_CYC_ONE);
    chk(LSBE_OFF_PC, 32'h0201);
    exec(mk(LSBE_OP_BTSC, 1'b0, 3'h3, 7'h28, 9'h000), LSBE_CYC_TWO);
    chk(LSBE_OFF_PC, 32'h0203);
    exec(mk(LSBE_OP_NOP, 1'b0, 3'h0, 7'h00, 9'h000), LSBE_CYC_ONE);
    chk(LSBE_OFF_PC, 32'h0204);
    chk(LSBE_OFF_STATUS, 32'h7);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_and();
    t_addc();
    t_asr();
    t_bits();
    t_branch();
    t_skip();
    end_sim();
  end
endmodule
